// [verilog/oap_pkg.sv]
// Constants, types and state layouts of the auto-poll bit checker.
package oap_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int SLEEP_BASE_MS = 10;
	localparam int SLEEP_BASE_CYC = SLEEP_BASE_MS * CYC_PER_MS;
	localparam int HOLD_MS = 4;
	localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
	localparam logic [2:0] BAD_LIMIT = 3'h4;
	localparam int WIDTH_W = 24;

	// Window base in microseconds at the narrowest bandwidth code
	localparam logic [9:0] WIN_US [0:7] = '{10'h23a, 10'h214, 10'h1ee, 10'h1c9,
		10'h1a3, 10'h17d, 10'h157, 10'h131};

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] CFG_OFF = 12'h000;
	localparam logic [11:0] STAT_OFF = 12'h004;
	localparam int AP_EN_BIT = 15;
	localparam int SLEEP_LSB = 12;
	localparam int WIN_LSB = 9;
	localparam int VCNT_LSB = 7;
	localparam int BW_LSB = 3;
	localparam logic [31:0] CFG_RST = 32'h0000_2e18;
	localparam logic [31:0] CFG_MASK = 32'h0000_ff98;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_AWAKE = 4'h1,
		ST_SLEEP = 4'h2,
		ST_POLL = 4'h4,
		ST_RECV = 4'h8
	} oap_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} oap_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} oap_apb_rsp_t;

	typedef struct packed {
		logic prev;
		logic edge_seen;
		logic [WIDTH_W-1:0] run;
		logic [WIDTH_W-1:0] width;
	} oap_meter_t;

	typedef struct packed {
		oap_state_t state;
		logic [31:0] cfg;
		logic [31:0] timer;
		logic [4:0] vcnt;
		logic [2:0] bcnt;
		logic fc;
		logic fa;
		logic hold;
		logic data;
		logic vbit;
		logic bbit;
		logic [31:0] prdata;
		logic slverr;
	} oap_core_t;

	localparam oap_core_t CORE_RST = '{state: ST_AWAKE, cfg: CFG_RST,
		timer: 32'h0000_0000, vcnt: 5'h00, bcnt: 3'h0, fc: 1'b1, fa: 1'b0,
		hold: 1'b0, data: 1'b0, vbit: 1'b0, bbit: 1'b0,
		prdata: 32'h0000_0000, slverr: 1'b0};

endpackage : oap_pkg

// [verilog/oap_pulse_meter.sv]
// Width meter for marks and spaces of the raw demodulated signal.
module oap_pulse_meter
	import oap_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire logic i_raw,
	input wire logic i_clear,
	output logic o_edge,
	output logic o_level,
	output logic [WIDTH_W-1:0] o_width,
	output logic [WIDTH_W-1:0] o_run
);

	oap_meter_t q;
	oap_meter_t n;

	// ------------------------------------------------------------
	// Counting
	// ------------------------------------------------------------
	always_comb
	begin
		n = q;
		n.prev = i_raw;
		n.edge_seen = 1'b0;
		if (i_clear)
		begin
			// Partial pulse before the clear is never reported
			n.run = '0;
		end
		else if (i_raw != q.prev)
		begin
			n.edge_seen = 1'b1;
			n.width = q.run;
			n.run = {{(WIDTH_W-1){1'b0}}, 1'b1};
		end
		else if (q.run != {WIDTH_W{1'b1}})
		begin
			// Saturates so a long gap never wraps to a short width
			n.run = q.run + {{(WIDTH_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			q <= '0;
		else
			q <= n;
	end

	assign o_edge = q.edge_seen;
	assign o_level = q.prev;
	assign o_width = q.width;
	assign o_run = q.run;

endmodule : oap_pulse_meter

// [verilog/oap_autopoll.sv]
// Auto-poll sequencer, bit checker, threshold hold and gain-loop enables.
module oap_autopoll
	import oap_pkg::*;
#(
	parameter int SLEEP_BASE_CYC_P = SLEEP_BASE_CYC,
	parameter int HOLD_CYC_P = HOLD_CYC,
	parameter int CYC_PER_US_P = CLK_MHZ
)
(
	input wire logic i_mclk,
	input wire logic i_srst,
	input wire oap_apb_req_t i_apb,
	output oap_apb_rsp_t o_apb,
	input wire logic i_demod_raw,
	input wire logic i_rise_fast,
	input wire logic i_loop_settled,
	output logic o_data,
	output logic o_sleep,
	output logic o_thresh_hold,
	output logic o_fast_charge,
	output logic o_fast_attack,
	output logic o_valid_bit,
	output logic o_bad_bit
);

	oap_core_t q;
	oap_core_t n;
	logic m_edge;
	logic m_level;
	logic [WIDTH_W-1:0] m_width;
	logic [WIDTH_W-1:0] m_run;
	logic apb_setup;
	logic apb_wr;
	logic cfg_hit;
	logic stat_hit;
	logic cfg_wr;
	logic [2:0] sleep_code;
	logic [2:0] win_code;
	logic [1:0] vcnt_code;
	logic [1:0] bw_code;
	logic [31:0] sleep_cyc;
	logic [WIDTH_W-1:0] win_cyc;
	logic [4:0] vtarget;
	logic is_valid;
	logic is_bad;
	logic [4:0] nv;
	logic [2:0] nb;

	// ------------------------------------------------------------
	// Pulse width measurement
	// ------------------------------------------------------------
	// Held cleared in sleep so the first width in polling starts at entry
	oap_pulse_meter u_meter (
		.i_mclk(i_mclk),
		.i_srst(i_srst),
		.i_raw(i_demod_raw),
		.i_clear(q.state == ST_SLEEP),
		.o_edge(m_edge),
		.o_level(m_level),
		.o_width(m_width),
		.o_run(m_run)
	);

	// ------------------------------------------------------------
	// Configuration decode
	// ------------------------------------------------------------
	assign sleep_code = q.cfg[SLEEP_LSB +: 3];
	assign win_code = q.cfg[WIN_LSB +: 3];
	assign vcnt_code = q.cfg[VCNT_LSB +: 2];
	assign bw_code = q.cfg[BW_LSB +: 2];
	assign sleep_cyc = 32'(SLEEP_BASE_CYC_P) << sleep_code;
	// Narrowest bandwidth gives the longest window, each step halves it
	assign win_cyc = WIDTH_W'((32'(WIN_US[win_code]) * 32'(CYC_PER_US_P)) >> bw_code);
	assign vtarget = (vcnt_code == 2'h0) ? 5'h00 : 5'(5'h01 << (3'(vcnt_code) + 3'h1));

	// Equal to the window is not longer than it, so it counts as bad
	assign is_valid = (q.state == ST_POLL) && m_edge && (m_width > win_cyc);
	assign is_bad = (q.state == ST_POLL) && m_edge && (m_width <= win_cyc);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	assign apb_setup = i_apb.psel && !i_apb.penable;
	assign apb_wr = i_apb.psel && i_apb.penable && i_apb.pwrite;
	assign cfg_hit = i_apb.paddr == CFG_OFF;
	assign stat_hit = i_apb.paddr == STAT_OFF;
	assign cfg_wr = apb_wr && cfg_hit;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		n = q;
		nv = q.vcnt;
		nb = q.bcnt;
		n.vbit = is_valid;
		n.bbit = is_bad;
		if (is_valid)
		begin
			nv = (q.vcnt == 5'h1f) ? q.vcnt : q.vcnt + 5'h01;
			nb = 3'h0;
		end
		else if (is_bad)
		begin
			nb = q.bcnt + 3'h1;
			nv = 5'h00;
		end
		case (q.state)
			ST_AWAKE:
			begin
				n.timer = 32'h0000_0000;
			end
			ST_SLEEP:
			begin
				// Only the sleep timer runs here; the fast-charge and fast-attack flags still follow their inputs
				if (q.timer >= sleep_cyc - 32'h0000_0001)
				begin
					n.state = ST_POLL;
					n.timer = 32'h0000_0000;
					n.vcnt = 5'h00;
					n.bcnt = 3'h0;
				end
				else
				begin
					n.timer = q.timer + 32'h0000_0001;
				end
			end
			ST_POLL:
			begin
				n.vcnt = nv;
				n.bcnt = nb;
				if (nb >= BAD_LIMIT)
				begin
					n.state = ST_SLEEP;
					n.timer = 32'h0000_0000;
				end
				else if (nv >= vtarget)
				begin
					n.state = ST_RECV;
				end
			end
			ST_RECV:
			begin
				// Signal loss is ignored here; only a write leaves
				n.state = ST_RECV;
			end
			default:
			begin
				n.state = ST_AWAKE;
			end
		endcase
		if (cfg_wr)
		begin
			n.cfg = i_apb.pwdata & CFG_MASK;
			n.state = i_apb.pwdata[AP_EN_BIT] ? ST_SLEEP : ST_AWAKE;
			n.timer = 32'h0000_0000;
			n.vcnt = 5'h00;
			n.bcnt = 3'h0;
		end

		// Output follows the raw signal only in the awake and receive states
		n.data = ((q.state == ST_AWAKE) || (q.state == ST_RECV)) && i_demod_raw;
		if (i_demod_raw)
			n.fc = 1'b0;
		if (i_rise_fast)
			n.fa = 1'b1;
		else if (i_loop_settled)
			n.fa = 1'b0;
		n.hold = !m_level && (m_run > WIDTH_W'(HOLD_CYC_P));

		// Read data is captured in setup so the access phase answers at once
		if (apb_setup)
		begin
			n.slverr = !(cfg_hit || stat_hit);
			if (cfg_hit)
				n.prdata = q.cfg;
			else if (stat_hit)
				n.prdata = {17'h0_0000, q.fa, q.fc, q.hold, q.bcnt, q.vcnt, q.state};
			else
				n.prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (i_srst)
			q <= CORE_RST;
		else
			q <= n;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_apb.prdata = q.prdata;
	assign o_apb.pready = i_apb.psel && i_apb.penable;
	assign o_apb.pslverr = i_apb.psel && i_apb.penable && q.slverr;
	assign o_data = q.data;
	assign o_sleep = q.state == ST_SLEEP;
	assign o_thresh_hold = q.hold;
	assign o_fast_charge = q.fc;
	assign o_fast_attack = q.fa;
	assign o_valid_bit = q.vbit;
	assign o_bad_bit = q.bbit;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_srst);

	property p_hold_enter;
		(!m_level && (m_run > WIDTH_W'(HOLD_CYC_P))) |=> o_thresh_hold;
	endproperty
	a_hold_enter: assert property (p_hold_enter) else $error("hold not entered");

	property p_fc_off;
		i_demod_raw |=> !o_fast_charge ##1 !o_fast_charge;
	endproperty
	a_fc_off: assert property (p_fc_off) else $error("fast charge back on");

	property p_fa;
		(i_rise_fast |=> o_fast_attack) and
		((i_loop_settled && !i_rise_fast) |=> !o_fast_attack);
	endproperty
	a_fa: assert property (p_fa) else $error("fast attack wrong");

	property p_ap_on;
		(cfg_wr && i_apb.pwdata[AP_EN_BIT]) |=> (q.state == ST_SLEEP) ##1 !o_data;
	endproperty
	a_ap_on: assert property (p_ap_on) else $error("auto-poll not entered");

	property p_ap_off;
		(cfg_wr && !i_apb.pwdata[AP_EN_BIT]) |=> (q.state == ST_AWAKE);
	endproperty
	a_ap_off: assert property (p_ap_off) else $error("awake mode not entered");

	property p_sleep_len;
		(q.state == ST_SLEEP) |-> (q.timer < sleep_cyc);
	endproperty
	a_sleep_len: assert property (p_sleep_len) else $error("sleep overran");

	property p_do_low;
		((q.state == ST_SLEEP) || (q.state == ST_POLL)) |=> !o_data;
	endproperty
	a_do_low: assert property (p_do_low) else $error("output not low");

	property p_bad4;
		(is_bad && (q.bcnt == 3'h3) && !cfg_wr) |=> (q.state == ST_SLEEP);
	endproperty
	a_bad4: assert property (p_bad4) else $error("no sleep after bad bits");

	property p_release;
		((q.state == ST_POLL) && (nv >= vtarget) && (nb < BAD_LIMIT) && !cfg_wr)
			|=> (q.state == ST_RECV);
	endproperty
	a_release: assert property (p_release) else $error("output not released");

	property p_stay;
		((q.state == ST_RECV) && !cfg_wr) |=> (q.state == ST_RECV);
	endproperty
	a_stay: assert property (p_stay) else $error("receive mode left");

	property p_clear;
		(is_valid && !cfg_wr) |=> (q.bcnt == 3'h0) && (q.vcnt != 5'h00);
	endproperty
	a_clear: assert property (p_clear) else $error("bad count not cleared");

	property p_entry;
		((q.state == ST_SLEEP) ##1 (q.state == ST_POLL)) |-> (q.vcnt == 5'h00) && (q.bcnt == 3'h0);
	endproperty
	a_entry: assert property (p_entry) else $error("counts not zero at poll");

	property p_vclear;
		(is_bad && !cfg_wr) |=> (q.vcnt == 5'h00) && (q.bcnt != 3'h0);
	endproperty
	a_vclear: assert property (p_vclear) else $error("valid count not cleared");

	property p_vtarget;
		vtarget == ((vcnt_code == 2'h0) ? 5'h00 : (vcnt_code == 2'h1) ? 5'h04 :
			(vcnt_code == 2'h2) ? 5'h08 : 5'h10);
	endproperty
	a_vtarget: assert property (p_vtarget) else $error("valid target decode wrong");

	property p_poll_start;
		((q.state == ST_SLEEP) && (q.timer == sleep_cyc - 32'h0000_0001) && !cfg_wr)
			|=> (q.state == ST_POLL);
	endproperty
	a_poll_start: assert property (p_poll_start) else $error("polling not entered");

	property p_one_kind;
		((q.state == ST_POLL) && m_edge) |=> (o_valid_bit != o_bad_bit);
	endproperty
	a_one_kind: assert property (p_one_kind) else $error("bit not classified once");

	property p_pass;
		((q.state == ST_RECV) && i_demod_raw) |=> o_data;
	endproperty
	a_pass: assert property (p_pass) else $error("data not passed");

	c_recv: cover property ((q.state == ST_POLL) ##1 (q.state == ST_RECV));
	c_back: cover property ((q.state == ST_POLL) ##1 (q.state == ST_SLEEP));
	c_wake: cover property ((q.state == ST_SLEEP) ##1 (q.state == ST_POLL));
	c_hold: cover property ($rose(o_thresh_hold));

endmodule : oap_autopoll

// [dv/oap_tx_model.sv]
// Transmitter model: on-off keyed bursts as seen at the raw demodulated node.
module oap_tx_model
(
	input wire logic i_mclk,
	input wire logic i_burst,
	input wire logic [7:0] i_half,
	output logic o_raw = 1'b0
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] cnt_q = 8'h00;

	// ------------------------------------------------------------
	// Burst shaping
	// ------------------------------------------------------------
	// No RF means a space, so the node idles low between bursts
	always @(posedge i_mclk)
	begin
		if (i_burst !== 1'b1)
		begin
			o_raw <= 1'b0;
			cnt_q <= 8'h00;
		end
		else if (cnt_q == i_half - 8'h01)
		begin
			o_raw <= ~o_raw;
			cnt_q <= 8'h00;
		end
		else
			cnt_q <= cnt_q + 8'h01;
	end
endmodule : oap_tx_model

// [dv/oap_autopoll_bench.sv]
// Self-checking bench for the auto-poll bit checker.
module oap_autopoll_bench
	import oap_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic i_mclk = 1'b0;
	logic i_srst = 1'b1;
	oap_apb_req_t apb_req = '0;
	oap_apb_rsp_t apb_rsp;
	logic raw;
	logic rise_fast = 1'b0;
	logic settled = 1'b0;
	logic burst = 1'b0;
	logic [7:0] half = 8'h0a;
	logic data, slp, hold, fc, fa, vb, bb;
	// Raw one cycle back, which is what the registered output shows now
	logic hist = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [31:0] rd;
	logic err;
	int fails = 0;
	int samples_checked = 0;
	int n;

	always #2 i_mclk = ~i_mclk;

	oap_tx_model tx_u (.i_mclk(i_mclk), .i_burst(burst), .i_half(half), .o_raw(raw));

	// Short counts keep sleep, hold and window in tens of cycles
	oap_autopoll #(.SLEEP_BASE_CYC_P(50), .HOLD_CYC_P(40), .CYC_PER_US_P(1)) dut_u (
		.i_mclk(i_mclk), .i_srst(i_srst), .i_apb(apb_req), .o_apb(apb_rsp),
		.i_demod_raw(raw), .i_rise_fast(rise_fast), .i_loop_settled(settled),
		.o_data(data), .o_sleep(slp), .o_thresh_hold(hold), .o_fast_charge(fc),
		.o_fast_attack(fa), .o_valid_bit(vb), .o_bad_bit(bb));

	// ------------------------------------------------------------
	// Compare and bus tasks
	// ------------------------------------------------------------
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, input logic exp);
		check_word({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask : check_bit

	task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge i_mclk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge i_mclk);
		apb_req.penable <= 1'b1;
		// Only the watchdog ends a wait that never sees ready
		do
		begin
			@(posedge i_mclk);
		end
		while (apb_rsp.pready !== 1'b1);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req <= '0;
	endtask : apb_xfer

	// Cycles spent asleep; the first edge after the write is already counted
	task automatic measure_sleep(output int cyc);
		cyc = 1;
		@(posedge i_mclk);
		mode <= 2'h2;
		while (slp === 1'b1 && cyc < 400)
		begin
			@(posedge i_mclk);
			cyc++;
		end
	endtask : measure_sleep

	// Waits for four bits of one kind in a row; the other kind restarts the run
	task automatic count_run(input logic want_valid, output int got);
		got = 0;
		for (int t = 0; t < 3000 && got < 4; t++)
		begin
			@(posedge i_mclk);
			if ((want_valid ? vb : bb) === 1'b1)
				got++;
			if ((want_valid ? bb : vb) === 1'b1)
				got = 0;
		end
	endtask : count_run

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// Output monitor
	// ------------------------------------------------------------
	always @(posedge i_mclk)
	begin
		hist <= raw;
		if (mode == 2'h1)
			check_bit(data, hist);
		if (mode == 2'h2)
			check_bit(data, 1'b0);
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (10) @(posedge i_mclk);
		i_srst <= 1'b0;
		@(posedge i_mclk);
		check_bit(fc, 1'b1);
		apb_xfer(1'b1, 12'h004, 32'hffff_ffff);
		check_bit(err, 1'b0);
		apb_xfer(1'b1, 12'h008, 32'h0000_0000);
		check_bit(err, 1'b1);
		apb_xfer(1'b0, 12'h008, 32'h0000_0000);
		check_bit(err, 1'b1);
		check_word(rd, 32'h0000_0000);
		// Defaults: stay awake, 40 ms sleep, window code 7, no valid bits, widest bandwidth
		apb_xfer(1'b0, 12'h000, 32'h0000_0000);
		check_word(rd, 32'h0000_2e18);
		apb_xfer(1'b0, 12'h004, 32'h0000_0000);
		check_word(rd & 32'h0000_200f, 32'h0000_2001);
		repeat (40) @(posedge i_mclk);
		check_bit(hold, 1'b1);
		check_bit(slp, 1'b0);
		rise_fast <= 1'b1;
		repeat (3) @(posedge i_mclk);
		check_bit(fa, 1'b1);
		rise_fast <= 1'b0;
		settled <= 1'b1;
		repeat (3) @(posedge i_mclk);
		check_bit(fa, 1'b0);
		burst <= 1'b1;
		repeat (30) @(posedge i_mclk);
		check_bit(fc, 1'b0);
		check_bit(hold, 1'b0);
		mode <= 2'h1;
		repeat (40) @(posedge i_mclk);
		// Auto-poll, 20 ms sleep, 38-cycle window, four valid bits, 60-cycle marks
		mode <= 2'h0;
		half <= 8'h3c;
		apb_xfer(1'b1, 12'h000, 32'h0000_9e98);
		measure_sleep(n);
		check_bit(n >= 99 && n <= 103, 1'b1);
		count_run(1'b1, n);
		mode <= 2'h0;
		check_bit(n == 4, 1'b1);
		repeat (4) @(posedge i_mclk);
		apb_xfer(1'b0, 12'h004, 32'h0000_0000);
		check_word(rd & 32'h0000_000f, 32'h0000_0008);
		mode <= 2'h1;
		repeat (200) @(posedge i_mclk);
		burst <= 1'b0;
		repeat (300) @(posedge i_mclk);
		check_bit(slp, 1'b0);
		apb_xfer(1'b0, 12'h004, 32'h0000_0000);
		check_word(rd & 32'h0000_000f, 32'h0000_0008);
		// Window code 0 widens the window to 71 cycles, so 60-cycle marks are bad
		mode <= 2'h0;
		apb_xfer(1'b1, 12'h000, 32'h0000_8098);
		burst <= 1'b1;
		measure_sleep(n);
		check_bit(n >= 49 && n <= 53, 1'b1);
		count_run(1'b0, n);
		check_bit(n == 4, 1'b1);
		repeat (2) @(posedge i_mclk);
		check_bit(slp, 1'b1);
		mode <= 2'h0;
		// Sixteen valid bits needed: still polling after four, receiving after sixteen
		apb_xfer(1'b1, 12'h000, 32'h0000_8f98);
		measure_sleep(n);
		check_bit(n >= 49 && n <= 53, 1'b1);
		count_run(1'b1, n);
		apb_xfer(1'b0, 12'h004, 32'h0000_0000);
		check_word(rd & 32'h0000_01ff, 32'h0000_0044);
		repeat (3) count_run(1'b1, n);
		mode <= 2'h0;
		check_bit(n == 4, 1'b1);
		repeat (4) @(posedge i_mclk);
		apb_xfer(1'b0, 12'h004, 32'h0000_0000);
		check_word(rd & 32'h0000_000f, 32'h0000_0008);
		apb_xfer(1'b1, 12'h000, 32'h0000_2e18);
		repeat (3) @(posedge i_mclk);
		mode <= 2'h1;
		repeat (100) @(posedge i_mclk);
		check_bit(slp, 1'b0);
		complete_run();
	end

	initial
	begin
		#200000;
		fails++;
		complete_run();
	end
endmodule : oap_autopoll_bench
